/* rtl/ctxb_regs.svh */
// Register offsets, field positions and limits of the CAN transmit buffer block.
`ifndef CTXB_REGS_SVH
`define CTXB_REGS_SVH
`define CTXB_NUM_BUF 3
`define CTXB_BUF_LIMIT 2'h3
`define CTXB_ADDR_HIGH 11:8
`define CTXB_ADDR_LOW 7:0
`define CTXB_BUF_SEL 7:6
`define CTXB_REG_SEL 5:0
`define CTXB_DATA_FLAG 5
`define CTXB_DATA_SEL 4:2
`define CTXB_OFF_CON 6'h00
`define CTXB_OFF_SIDH 6'h04
`define CTXB_OFF_SIDL 6'h08
`define CTXB_OFF_EIDH 6'h0c
`define CTXB_OFF_EIDL 6'h10
`define CTXB_OFF_DLC 6'h14
`define CTXB_ADDR_TEC 8'hc0
`define CTXB_ADDR_STAT 8'hc4
`define CTXB_BYTE 7:0
`define CTXB_CON_ABT 6
`define CTXB_CON_LARB 5
`define CTXB_CON_ERR 4
`define CTXB_CON_REQ 3
`define CTXB_CON_PRI 1:0
`define CTXB_SIDL_SID 7:5
`define CTXB_SIDL_EXT 3
`define CTXB_SIDL_EID 1:0
`define CTXB_DLC_RTR 6
`define CTXB_DLC_CODE 3:0
`define CTXB_STAT_BOFF 2
`define CTXB_STAT_PASS 1
`define CTXB_STAT_WARN 0
`define CTXB_SID_HI 10:3
`define CTXB_SID_LO 2:0
`define CTXB_EID_TOP 17:16
`define CTXB_EID_MID 15:8
`define CTXB_EID_BOT 7:0
`define CTXB_ID_STD_PAD 18'h00000
`define CTXB_ID_EXT_PART 28:11
`define CTXB_PASSIVE_LIMIT 8'h7f
`define CTXB_WARN_LIMIT 8'h5f
`define CTXB_TEC_STEP_UP 9'h008
`define CTXB_TEC_MAX 9'h0ff
`define CTXB_TEC_FULL 8'hff
`define CTXB_RECOV_LAST 7'h7f
`endif

/* rtl/ctxb_pkg.sv */
// Types shared by the CAN transmit buffer block.
`include "ctxb_regs.svh"
package ctxb_pkg;
    typedef enum logic [1:0] {
        CTXB_IDLE = 2'b00,
        CTXB_SENDING = 2'b01,
        CTXB_ABORTING = 2'b10
    } ctxb_tx_e;
    typedef struct packed {
        logic req;
        logic abt;
        logic larb;
        logic err;
        logic [1:0] pri;
        logic [10:0] sid;
        logic ext;
        logic [17:0] eid;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
    } ctxb_buf_s;
    typedef struct packed {
        logic [28:0] id;
        logic ext;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
        logic [1:0] idx;
    } ctxb_frame_s;
    typedef struct packed {
        logic done;
        logic lost_arb;
        logic bus_err;
        logic recessive_11;
        logic tec_up;
        logic tec_down;
    } ctxb_evt_s;
    typedef struct packed {
        ctxb_buf_s [`CTXB_NUM_BUF-1:0] bufs;
        ctxb_tx_e tx;
        logic [1:0] act;
        logic [7:0] tec;
        logic boff;
        logic pass;
        logic warn;
        logic [6:0] recov;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic fvalid;
        ctxb_frame_s frame;
        logic abort_req;
    } ctxb_state_s;
endpackage : ctxb_pkg

/* rtl/ctxb_top.sv */
// Three CAN transmit buffers, their selection logic and the transmit error counter.
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// Overview of operation
// [R1] Aborted flag sets on an abort, clears when a new request is written.
// [R2] Lost arbitration flag sets when the active message loses arbitration.
// [R3] Bus error flag sets when a bus error hits the active message.
// [R4] Writing one to send_request sets it and clears the three status flags.
// [R5] Successful transmission clears send_request by hardware.
// [R6] Writing zero while send_request is set requests an abort.
// [R7] Pending buffers are ordered by priority, level 3 highest, 0 lowest.
// [R8] Priority never alters the transmitted identifier.
// [R9] Extended enable sends an extended frame, base bits become bits 28 to 18.
// [R10] Standard frame ignores the eighteen extension bits.
// [R11] Identifier high byte holds base bits 10 to 3.
// [R12] Identifier low byte holds base bits 2 to 0 and extension bits 17, 16.
// [R13] Two extension bytes hold bits 15 to 8 and 7 to 0, read-write.
// [R14] Three buffers, each with eight payload byte registers from byte 0.
// [R15] Remote request flag is copied into the frame's remote request bit.
// [R16] Length code 0 to 8 gives bytes, codes 9 to 15 are reserved.
// [R17] Eight-bit read-only error tally; overflow enters bus-off.
// [R18] Tally clears after 128 runs of 11 recessive bits.
// [R19] Passive flag is high while the tally exceeds 127.
// [R20] Warning flag is high while the tally is above 95 and not above 127.
// [R21] Equal priorities resolve to the lowest buffer index.
// [R22] Unimplemented bits ignore writes and read as zero.
// -----------------------------------------------------------------------------
module ctxb_top
    import ctxb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_start,
    input ctxb_evt_s evt,
    output logic frame_valid,
    output ctxb_frame_s frame,
    output logic abort_req,
    output logic bus_off,
    output logic tx_passive_flag,
    output logic tx_warning_flag
);

    ctxb_state_s s_q;
    ctxb_state_s s_d;
    logic [1:0] bi;
    logic [5:0] ro;
    logic [5:0] byte_pos;
    logic is_buf;
    logic hit;
    logic acc;
    logic wr;
    logic [31:0] rd;
    ctxb_buf_s b;
    logic found;
    logic [1:0] best_pri;
    logic [1:0] best_i;
    logic [8:0] tec_sum;

    assign bi = paddr[`CTXB_BUF_SEL];
    assign ro = paddr[`CTXB_REG_SEL];
    assign byte_pos = {paddr[`CTXB_DATA_SEL], 3'h0};
    assign is_buf = (paddr[`CTXB_ADDR_HIGH] == 4'h0) && (bi < `CTXB_BUF_LIMIT);
    assign acc = psel & penable & s_q.pready;
    assign wr = acc & pwrite & hit;

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        rd = 32'h0000_0000;
        hit = 1'b0;
        b = s_q.bufs[bi];
        found = 1'b0;
        best_pri = 2'h0;
        best_i = 2'h0;
        tec_sum = 9'h000;
        // Read decode; bits that are not listed stay zero.
        if (is_buf) begin
            hit = 1'b1;
            if (paddr[`CTXB_DATA_FLAG]) begin
                rd[`CTXB_BYTE] = b.data[byte_pos +: 8]; // R14
            end else if (ro == `CTXB_OFF_CON) begin
                rd[`CTXB_CON_ABT] = b.abt; // R22
                rd[`CTXB_CON_LARB] = b.larb;
                rd[`CTXB_CON_ERR] = b.err;
                rd[`CTXB_CON_REQ] = b.req;
                rd[`CTXB_CON_PRI] = b.pri;
            end else if (ro == `CTXB_OFF_SIDH) begin
                rd[`CTXB_BYTE] = b.sid[`CTXB_SID_HI]; // R11
            end else if (ro == `CTXB_OFF_SIDL) begin
                rd[`CTXB_SIDL_SID] = b.sid[`CTXB_SID_LO]; // R12
                rd[`CTXB_SIDL_EXT] = b.ext;
                rd[`CTXB_SIDL_EID] = b.eid[`CTXB_EID_TOP];
            end else if (ro == `CTXB_OFF_EIDH) begin
                rd[`CTXB_BYTE] = b.eid[`CTXB_EID_MID]; // R13
            end else if (ro == `CTXB_OFF_EIDL) begin
                rd[`CTXB_BYTE] = b.eid[`CTXB_EID_BOT]; // R13
            end else if (ro == `CTXB_OFF_DLC) begin
                rd[`CTXB_DLC_RTR] = b.rtr;
                rd[`CTXB_DLC_CODE] = b.dlc;
            end else begin
                hit = 1'b0;
            end
        end else if (paddr[`CTXB_ADDR_HIGH] != 4'h0) begin
            hit = 1'b0;
        end else if (paddr[`CTXB_ADDR_LOW] == `CTXB_ADDR_TEC) begin
            hit = 1'b1;
            rd[`CTXB_BYTE] = s_q.tec; // R17
        end else if (paddr[`CTXB_ADDR_LOW] == `CTXB_ADDR_STAT) begin
            hit = 1'b1;
            rd[`CTXB_STAT_BOFF] = s_q.boff;
            rd[`CTXB_STAT_PASS] = s_q.pass;
            rd[`CTXB_STAT_WARN] = s_q.warn;
        end else begin
            hit = 1'b0;
        end

        // The access phase always takes one wait cycle so that pready is a flop.
        s_d.pready = psel & penable & ~s_q.pready;
        s_d.prdata = 32'h0000_0000;
        s_d.pslverr = 1'b0;
        if (psel & penable & ~s_q.pready) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : rd;
            s_d.pslverr = ~hit;
        end

        // Register writes take effect only at the completing edge.
        if (wr & is_buf) begin
            if (paddr[`CTXB_DATA_FLAG]) begin
                s_d.bufs[bi].data[byte_pos +: 8] = pwdata[`CTXB_BYTE]; // R14
            end else if (ro == `CTXB_OFF_CON) begin
                s_d.bufs[bi].pri = pwdata[`CTXB_CON_PRI];
                if (pwdata[`CTXB_CON_REQ]) begin
                    s_d.bufs[bi].req = 1'b1; // R4
                    s_d.bufs[bi].abt = 1'b0; // R1
                    s_d.bufs[bi].larb = 1'b0;
                    s_d.bufs[bi].err = 1'b0;
                end else if (s_q.bufs[bi].req) begin
                    if ((s_q.tx != CTXB_IDLE) && (s_q.act == bi)) begin
                        s_d.tx = CTXB_ABORTING; // R6
                    end else begin
                        s_d.bufs[bi].req = 1'b0; // R6
                        s_d.bufs[bi].abt = 1'b1; // R1
                    end
                end
            end else if (ro == `CTXB_OFF_SIDH) begin
                s_d.bufs[bi].sid[`CTXB_SID_HI] = pwdata[`CTXB_BYTE]; // R11
            end else if (ro == `CTXB_OFF_SIDL) begin
                s_d.bufs[bi].sid[`CTXB_SID_LO] = pwdata[`CTXB_SIDL_SID]; // R12
                s_d.bufs[bi].ext = pwdata[`CTXB_SIDL_EXT];
                s_d.bufs[bi].eid[`CTXB_EID_TOP] = pwdata[`CTXB_SIDL_EID]; // R12
            end else if (ro == `CTXB_OFF_EIDH) begin
                s_d.bufs[bi].eid[`CTXB_EID_MID] = pwdata[`CTXB_BYTE]; // R13
            end else if (ro == `CTXB_OFF_EIDL) begin
                s_d.bufs[bi].eid[`CTXB_EID_BOT] = pwdata[`CTXB_BYTE]; // R13
            end else if (ro == `CTXB_OFF_DLC) begin
                s_d.bufs[bi].rtr = pwdata[`CTXB_DLC_RTR];
                s_d.bufs[bi].dlc = pwdata[`CTXB_DLC_CODE]; // R16
            end
        end

        // Engine events come after software writes, so a set by hardware wins.
        case (s_q.tx)
            CTXB_IDLE: begin
                if (tx_start & s_q.fvalid) begin
                    s_d.tx = CTXB_SENDING;
                    s_d.act = s_q.frame.idx;
                end
            end
            CTXB_SENDING, CTXB_ABORTING: begin
                if (evt.done) begin
                    s_d.bufs[s_q.act].req = 1'b0; // R5
                    s_d.tx = CTXB_IDLE;
                end else if (evt.lost_arb | evt.bus_err) begin
                    if (evt.lost_arb) begin
                        s_d.bufs[s_q.act].larb = 1'b1; // R2
                    end
                    if (evt.bus_err) begin
                        s_d.bufs[s_q.act].err = 1'b1; // R3
                    end
                    if (s_d.tx == CTXB_ABORTING) begin
                        s_d.bufs[s_q.act].req = 1'b0; // R6
                        s_d.bufs[s_q.act].abt = 1'b1; // R1
                    end
                    s_d.tx = CTXB_IDLE;
                end
            end
            default: begin
                s_d.tx = CTXB_IDLE;
            end
        endcase
        s_d.abort_req = (s_d.tx == CTXB_ABORTING);

        // Selection works on the next state so an aborted buffer is never offered.
        for (int i = 0; i < `CTXB_NUM_BUF; i++) begin
            if (s_d.bufs[i].req && (!found || (s_d.bufs[i].pri > best_pri))) begin
                found = 1'b1; // R7 R21
                best_pri = s_d.bufs[i].pri;
                best_i = 2'(i);
            end
        end
        s_d.fvalid = found & (s_d.tx == CTXB_IDLE) & ~s_q.boff;
        s_d.frame.idx = best_i;
        s_d.frame.ext = s_d.bufs[best_i].ext;
        if (s_d.bufs[best_i].ext) begin
            s_d.frame.id = {s_d.bufs[best_i].sid, s_d.bufs[best_i].eid}; // R9 R8
        end else begin
            s_d.frame.id = {`CTXB_ID_STD_PAD, s_d.bufs[best_i].sid}; // R10 R8
        end
        s_d.frame.rtr = s_d.bufs[best_i].rtr; // R15
        s_d.frame.dlc = s_d.bufs[best_i].dlc; // R16
        s_d.frame.data = s_d.bufs[best_i].data;

        // Error tally; a bus-off node only counts recovery runs.
        if (s_q.boff) begin
            if (evt.recessive_11) begin
                if (s_q.recov == `CTXB_RECOV_LAST) begin
                    s_d.tec = 8'h00; // R18
                    s_d.boff = 1'b0;
                    s_d.recov = 7'h00;
                end else begin
                    s_d.recov = s_q.recov + 7'h01;
                end
            end
        end else if (evt.tec_up) begin
            tec_sum = {1'b0, s_q.tec} + `CTXB_TEC_STEP_UP;
            if (tec_sum > `CTXB_TEC_MAX) begin
                s_d.boff = 1'b1; // R17
                s_d.tec = `CTXB_TEC_FULL;
                s_d.fvalid = 1'b0;
            end else begin
                s_d.tec = tec_sum[7:0];
            end
        end else if (evt.tec_down && (s_q.tec != 8'h00)) begin
            s_d.tec = s_q.tec - 8'h01;
        end
        s_d.pass = (s_d.tec > `CTXB_PASSIVE_LIMIT); // R19
        s_d.warn = (s_d.tec > `CTXB_WARN_LIMIT) && (s_d.tec <= `CTXB_PASSIVE_LIMIT); // R20
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign frame_valid = s_q.fvalid;
    assign frame = s_q.frame;
    assign abort_req = s_q.abort_req;
    assign bus_off = s_q.boff;
    assign tx_passive_flag = s_q.pass;
    assign tx_warning_flag = s_q.warn;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_con;
    logic [`CTXB_NUM_BUF-1:0] prio_bad;
    ctxb_buf_s ob;
    assign wr_con = wr & is_buf & ~paddr[`CTXB_DATA_FLAG] & (ro == `CTXB_OFF_CON);
    assign ob = s_q.bufs[s_q.frame.idx];
    for (genvar g = 0; g < `CTXB_NUM_BUF; g++) begin : g_prio
        assign prio_bad[g] = s_q.fvalid & s_q.bufs[g].req &
            ((s_q.bufs[g].pri > ob.pri) |
            ((s_q.bufs[g].pri == ob.pri) & (2'(g) < s_q.frame.idx)));
    end

    sequence seq_idle_abort;
        wr_con && !pwdata[`CTXB_CON_REQ] && s_q.bufs[bi].req && (s_q.tx == CTXB_IDLE);
    endsequence
    sequence seq_active_abort;
        wr_con && !pwdata[`CTXB_CON_REQ] && (s_q.tx == CTXB_SENDING) && (s_q.act == bi) &&
            !evt.done && !evt.lost_arb && !evt.bus_err;
    endsequence
    sequence seq_abort_end;
        (s_q.tx == CTXB_ABORTING) && !evt.done && (evt.lost_arb || evt.bus_err);
    endsequence

    AST_ABORT_IDLE: assert property (seq_idle_abort |=> // R6
        s_q.bufs[$past(bi)].abt && !s_q.bufs[$past(bi)].req)
        else $error("idle abort did not set aborted flag");

    AST_ABORT_REQ: assert property (seq_active_abort |=> abort_req) // R6
        else $error("active abort not passed on");

    AST_ABORT_ACTIVE: assert property (seq_abort_end |=> // R1
        s_q.bufs[$past(s_q.act)].abt && !s_q.bufs[$past(s_q.act)].req && !abort_req)
        else $error("active abort not completed");

    AST_REQ_CLEARS: assert property ((wr_con && pwdata[`CTXB_CON_REQ] && s_q.tx == CTXB_IDLE) // R4
        |=> s_q.bufs[$past(bi)].req && !s_q.bufs[$past(bi)].abt &&
        !s_q.bufs[$past(bi)].larb && !s_q.bufs[$past(bi)].err)
        else $error("request write did not clear status");

    AST_DONE: assert property ((s_q.tx != CTXB_IDLE && evt.done) |=> // R5
        !s_q.bufs[$past(s_q.act)].req && s_q.tx == CTXB_IDLE)
        else $error("send request not cleared after success");

    AST_LARB: assert property ((s_q.tx != CTXB_IDLE && evt.lost_arb && !evt.done) |=> // R2
        s_q.bufs[$past(s_q.act)].larb)
        else $error("lost arbitration flag not set");

    AST_BUS_ERR: assert property ((s_q.tx != CTXB_IDLE && evt.bus_err && !evt.done) |=> // R3
        s_q.bufs[$past(s_q.act)].err)
        else $error("bus error flag not set");

    AST_PRIO: assert property (frame_valid |-> prio_bad == '0) // R7
        else $error("offered buffer is not the highest priority");

    AST_STD_ID: assert property ((frame_valid && !frame.ext) |-> // R10
        frame.id[`CTXB_ID_EXT_PART] == `CTXB_ID_STD_PAD)
        else $error("standard frame carries extension bits");

    AST_OVERFLOW: assert property ((!bus_off && evt.tec_up && // R17
        ({1'b0, s_q.tec} + `CTXB_TEC_STEP_UP > `CTXB_TEC_MAX)) |=> bus_off)
        else $error("tally overflow did not enter bus-off");

    AST_RECOVER: assert property ((bus_off && evt.recessive_11 && // R18
        s_q.recov == `CTXB_RECOV_LAST) |=> s_q.tec == 8'h00 && !bus_off)
        else $error("bus-off recovery did not clear tally");

    AST_PASSIVE: assert property (tx_passive_flag == (s_q.tec > `CTXB_PASSIVE_LIMIT)) // R19
        else $error("passive flag disagrees with tally");

    AST_WARN: assert property (tx_warning_flag == ((s_q.tec > `CTXB_WARN_LIMIT) && // R20
        !tx_passive_flag))
        else $error("warning flag disagrees with tally");

    AST_APB_READY: assert property ((psel && penable && !pready) |=> pready) // R22
        else $error("access phase not answered after one wait cycle");

    AST_SLVERR: assert property (pslverr |-> pready) // R22
        else $error("error response outside the answer");

    AST_OFFER_REQ: assert property (frame_valid |-> ob.req) // R7
        else $error("offered buffer has no request");

    AST_EXT_ID: assert property ((frame_valid && frame.ext) |-> // R9
        frame.id == {ob.sid, ob.eid})
        else $error("extended identifier wrong");

    AST_STD_SID: assert property ((frame_valid && !frame.ext) |-> // R8
        frame.id == {`CTXB_ID_STD_PAD, ob.sid})
        else $error("standard identifier altered");

    AST_RTR_COPY: assert property (frame_valid |-> frame.rtr == ob.rtr) // R15
        else $error("remote request flag not copied");

    AST_DLC_COPY: assert property (frame_valid |-> frame.dlc == ob.dlc) // R16
        else $error("length code not passed");

    AST_BOFF_HOLD: assert property (bus_off |-> // R17
        !frame_valid && s_q.tec == `CTXB_TEC_FULL)
        else $error("bus-off node offers a frame");

endmodule : ctxb_top

/* verification/ctxb_engine_model.sv */
// Behavioural model of the CAN protocol engine that takes frames from the buffers.
`timescale 1ns/100ps
module ctxb_engine_model
    import ctxb_pkg::*;
(
    input wire logic pclk,
    input wire logic frame_valid,
    input wire logic abort_req,
    output logic tx_start,
    output ctxb_evt_s evt
);
    // -------------------------------------------------------------------------
    // Engine actions
    // -------------------------------------------------------------------------
    logic abort_seen;
    initial begin
        tx_start = 1'b0;
        evt = '0;
        abort_seen = 1'b0;
    end
    // One transmission: kind 0 ends well, 1 loses arbitration, 2 meets a bus error.
    // A pending abort turns the end into lost arbitration, as a real engine cannot undo bits.
    task automatic shot(input int kind, input int dly);
        ctxb_evt_s e;
        e = '0;
        @(posedge pclk);
        while (frame_valid !== 1'b1) @(posedge pclk);
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
        repeat (dly) @(posedge pclk);
        abort_seen = abort_req;
        e.done = (kind == 0) && !abort_seen;
        e.lost_arb = (kind == 1) || abort_seen;
        e.bus_err = (kind == 2) && !abort_seen;
        evt <= e;
        @(posedge pclk);
        evt <= '0;
    endtask : shot
    task automatic pulse(input ctxb_evt_s e, input int n);
        repeat (n) begin
            @(posedge pclk);
            evt <= e;
            @(posedge pclk);
            evt <= '0;
        end
    endtask : pulse
endmodule : ctxb_engine_model

/* verification/tb_ctxb_top.sv */
// Self-checking bench of the CAN transmit buffer block.
`timescale 1ns/100ps
`include "ctxb_regs.svh"
module tb_ctxb_top
    import ctxb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_start, frame_valid;
    logic abort_req, bus_off, tx_passive_flag, tx_warning_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    ctxb_evt_s evt;
    ctxb_frame_s frame;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    ctxb_frame_s fq[$];
    logic [10:0] sid[3];
    logic [17:0] eid[3];
    logic [63:0] dat[3];
    logic ext[3] = '{1'b0, 1'b1, 1'b0};
    logic rtr[3] = '{1'b1, 1'b0, 1'b0};
    logic [3:0] dlc[3] = '{4'h8, 4'h9, 4'h0};
    logic [1:0] pri[3] = '{2'h1, 2'h3, 2'h1};
    logic [5:0] st_ev[7] = '{6'h02, 6'h01, 6'h02, 6'h02, 6'h02, 6'h04, 6'h04};
    int st_n[7] = '{12, 1, 4, 1, 16, 127, 1};
    logic [7:0] st_tec[7] = '{8'h60, 8'h5f, 8'h7f, 8'h87, 8'hff, 8'hff, 8'h00};
    logic [7:0] st_fl[7] = '{8'h01, 8'h00, 8'h01, 8'h02, 8'h06, 8'h06, 8'h00};

    ctxb_top i_ctxb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_start(tx_start), .evt(evt), .frame_valid(frame_valid),
        .frame(frame), .abort_req(abort_req), .bus_off(bus_off),
        .tx_passive_flag(tx_passive_flag), .tx_warning_flag(tx_warning_flag));
    ctxb_engine_model u_engine (.pclk(pclk), .frame_valid(frame_valid),
        .abort_req(abort_req), .tx_start(tx_start), .evt(evt));

    // -------------------------------------------------------------------------
    // Checking and reporting
    // -------------------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] x);
        n_checks++;
        if (got !== x) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, x);
        end
    endtask : cmp_rd
    task automatic cmp_frame(input ctxb_frame_s got, input ctxb_frame_s x);
        n_checks++;
        if (got !== x) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, x);
        end
    endtask : cmp_frame
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            cmp_rd({prdata & e[64:33], pslverr}, e[32:0]);
        end
        if (tx_start === 1'b1 && frame_valid === 1'b1) begin
            cmp_frame(frame, fq.size() > 0 ? fq.pop_front() : 'x);
        end
    end
    // Generous ceiling: the whole sequence needs well under a thousand cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            conclude();
        end
    end

    // -------------------------------------------------------------------------
    // Bus tasks
    // -------------------------------------------------------------------------
    // An idle cycle precedes each transfer so psel is never driven twice in a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            input logic [31:0] m, input logic [7:0] x, input logic er);
        exp_q.push_back({m, 24'h0, x, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, {4'h0, a}, d, 32'h0, 8'h00, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
        apb(1'b0, {4'h0, a}, 8'h00, {24'hffffff, m}, x & m, 1'b0);
    endtask : rd
    function automatic logic [7:0] ad(input int n, input logic [5:0] off);
        return {n[1:0], off};
    endfunction : ad
    function automatic ctxb_frame_s mk(input int n);
        return '{id: ext[n] ? {sid[n], eid[n]} : {18'h0, sid[n]}, ext: ext[n], rtr: rtr[n],
            dlc: dlc[n], data: dat[n], idx: n[1:0]};
    endfunction : mk

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h8109cd93));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CTXB_ADDR_TEC, 8'h00);
        rd(`CTXB_ADDR_STAT, 8'h00);
        rd(ad(0, `CTXB_OFF_CON), 8'h00);
        wr(`CTXB_ADDR_TEC, 8'hff);
        rd(`CTXB_ADDR_TEC, 8'h00);
        apb(1'b0, 12'h100, 8'h00, 32'hffffffff, 8'h00, 1'b1);
        for (int n = 0; n < 3; n++) begin
            sid[n] = 11'($urandom);
            eid[n] = 18'($urandom);
            dat[n] = {$urandom, $urandom};
            wr(ad(n, `CTXB_OFF_SIDH), sid[n][10:3]);
            wr(ad(n, `CTXB_OFF_SIDL), {sid[n][2:0], 1'b1, ext[n], 1'b1, eid[n][17:16]});
            rd(ad(n, `CTXB_OFF_SIDL), {sid[n][2:0], 1'b0, ext[n], 1'b0, eid[n][17:16]});
            wr(ad(n, `CTXB_OFF_EIDH), eid[n][15:8]);
            wr(ad(n, `CTXB_OFF_EIDL), eid[n][7:0]);
            rd(ad(n, `CTXB_OFF_EIDH), eid[n][15:8]);
            wr(ad(n, `CTXB_OFF_DLC), {1'b1, rtr[n], 2'b11, dlc[n]});
            rd(ad(n, `CTXB_OFF_DLC), {1'b0, rtr[n], 2'b00, dlc[n]});
            for (int m = 0; m < 8; m++)
                wr(ad(n, 6'h20 | {m[2:0], 2'b00}), dat[n][8*m+:8]);
            for (int m = 0; m < 8; m++) rd(ad(n, 6'h20 | {m[2:0], 2'b00}), dat[n][8*m+:8]);
            wr(ad(n, `CTXB_OFF_CON), {6'h23, pri[n]});
            rd(ad(n, `CTXB_OFF_CON), {6'h02, pri[n]});
        end
        fq.push_back(mk(1));
        fq.push_back(mk(0));
        fq.push_back(mk(2));
        repeat (3) u_engine.shot(0, $urandom_range(0, 5));
        for (int n = 0; n < 3; n++) rd(ad(n, `CTXB_OFF_CON), {6'h00, pri[n]});
        // Lost arbitration, bus error and a fresh request on buffer 0.
        wr(ad(0, `CTXB_OFF_CON), {6'h02, pri[0]});
        fq.push_back(mk(0));
        u_engine.shot(1, 1);
        rd(ad(0, `CTXB_OFF_CON), {6'h0a, pri[0]});
        wr(ad(0, `CTXB_OFF_CON), {6'h02, pri[0]});
        rd(ad(0, `CTXB_OFF_CON), {6'h02, pri[0]});
        fq.push_back(mk(0));
        u_engine.shot(2, 3);
        rd(ad(0, `CTXB_OFF_CON), {6'h06, pri[0]});
        wr(ad(0, `CTXB_OFF_CON), {6'h02, pri[0]});
        fq.push_back(mk(0));
        u_engine.shot(0, 0);
        rd(ad(0, `CTXB_OFF_CON), {6'h00, pri[0]});
        // Abort while idle, then abort while the frame is on the bus.
        wr(ad(1, `CTXB_OFF_CON), {6'h02, pri[1]});
        wr(ad(1, `CTXB_OFF_CON), {6'h00, pri[1]});
        rd(ad(1, `CTXB_OFF_CON), {6'h10, pri[1]});
        wr(ad(1, `CTXB_OFF_CON), {6'h02, pri[1]});
        rd(ad(1, `CTXB_OFF_CON), {6'h02, pri[1]});
        fq.push_back(mk(1));
        fork
            u_engine.shot(0, 14);
            begin
                repeat (5) @(posedge pclk);
                wr(ad(1, `CTXB_OFF_CON), {6'h00, pri[1]});
            end
        join
        cmp_rd({32'h0, u_engine.abort_seen}, 33'h1);
        rd(ad(1, `CTXB_OFF_CON), 8'h40, 8'h48);
        // Error tally thresholds, saturation, bus-off and recovery.
        for (int s = 0; s < 7; s++) begin
            u_engine.pulse(st_ev[s], st_n[s]);
            rd(`CTXB_ADDR_TEC, st_tec[s]);
            rd(`CTXB_ADDR_STAT, st_fl[s]);
            cmp_rd(33'({bus_off, tx_passive_flag, tx_warning_flag}), 33'(st_fl[s]));
        end
        conclude();
    end
endmodule : tb_ctxb_top
